//--- fdc_pkg.sv
// Shared constants, state encoding and reset values for the FIFO DRAM controller.
`default_nettype none

package fdc_pkg;

    localparam int PTR_W  = 16;
    localparam int ROW_W  = 8;
    localparam int STAT_W = 16;

    localparam int CLK_PERIOD_NS = 100;
    localparam int MAX_CLK_MHZ   = 5;

    // Refresh spacing: the longest allowed time rounds down to whole cycles.
    localparam int REFRESH_PERIOD_NS  = 15600;
    localparam int REFRESH_PERIOD_CYC = REFRESH_PERIOD_NS / CLK_PERIOD_NS;
    localparam int REFRESH_LOW_CYC    = REFRESH_PERIOD_CYC / 2;
    localparam int REFRESH_ROWS       = 256;
    localparam int REFRESH_WINDOW_NS  = 4000000;
    localparam bit REFRESH_FITS       =
        (REFRESH_PERIOD_NS * REFRESH_ROWS) <= REFRESH_WINDOW_NS;
    localparam int RF_TIMER_W         = 8;

    localparam logic [STAT_W-1:0] STATUS_EMPTY = 16'h0000;
    localparam logic [STAT_W-1:0] STATUS_FULL  = 16'hFFFF;
    localparam int                HALF_BIT     = 15;
    localparam logic [PTR_W-1:0]  PTR_RESET    = 16'h0000;
    localparam logic              STROBE_OFF   = 1'b1;

    localparam int DATA_W_DEF     = 8;
    localparam int FIFO_DEPTH_DEF = 16;

    // One-hot controller states.
    typedef enum logic [7:0] {
        ST_IDLE  = 8'h01,
        ST_ROW   = 8'h02,
        ST_RAS   = 8'h04,
        ST_COL   = 8'h08,
        ST_CAS   = 8'h10,
        ST_HOLD  = 8'h20,
        ST_RFCAS = 8'h40,
        ST_RFRAS = 8'h80
    } fdc_state_t;

endpackage : fdc_pkg

`default_nettype wire

//--- fdc_stream_if.sv
// Valid/ready word stream between the controller and its write-data FIFO.
`default_nettype none

interface fdc_stream_if #(
    parameter int W = 8
);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport source (output valid, output data, input ready);
    modport sink   (input valid, input data, output ready);
endinterface : fdc_stream_if

`default_nettype wire

//--- fdc_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
`default_nettype none

module fdc_fifo
    import fdc_pkg::*;
#(
    parameter int WIDTH = DATA_W_DEF,
    parameter int DEPTH = FIFO_DEPTH_DEF
) (
    input  wire logic   mclk,
    input  wire logic   rst_b,
    fdc_stream_if.sink   fillPort,
    fdc_stream_if.source drainPort
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0]               wrIdx;
        logic [AW-1:0]               rdIdx;
        logic [AW:0]                 count;
        logic                        inReady;
        logic                        outValid;
    } fdc_fifo_st_t;

    fdc_fifo_st_t q;
    fdc_fifo_st_t n;
    logic         push;
    logic         pop;

    // Handshakes; ready and valid are registered so full and empty are exact.
    assign push = fillPort.valid & q.inReady;
    assign pop  = drainPort.ready & q.outValid;

    assign fillPort.ready  = q.inReady;
    assign drainPort.valid = q.outValid;
    assign drainPort.data  = q.mem[q.rdIdx];

    // Next state: store, advance indices, recount.
    always_comb
    begin
        n = q;
        if (push)
        begin
            n.mem[q.wrIdx] = fillPort.data;
            n.wrIdx        = q.wrIdx + 1'b1;
        end
        if (pop)
        begin
            n.rdIdx = q.rdIdx + 1'b1;
        end
        if (push && !pop)
        begin
            n.count = q.count + 1'b1;
        end
        else if (pop && !push)
        begin
            n.count = q.count - 1'b1;
        end
        n.inReady  = (n.count != (AW + 1)'(DEPTH));
        n.outValid = (n.count != '0);
    end

    // State register.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q         <= '0;
            q.inReady <= 1'b1;
        end
        else
        begin
            q <= n;
        end
    end
endmodule : fdc_fifo

`default_nettype wire

//--- fdc_controller.sv
// FIFO DRAM controller: arbitration, strobe sequencing, pointers and status flags.
`default_nettype none

module fdc_controller
    import fdc_pkg::*;
#(
    parameter int DATA_W     = DATA_W_DEF,
    parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              readRequestN,
    input  wire logic              writeRequestN,
    input  wire logic [DATA_W-1:0] writeData,
    input  wire logic              writeDataValid,
    output logic                   writeDataReady,
    output logic [DATA_W-1:0]      readData,
    output logic                   readDataValid,
    output logic                   readyRead,
    output logic                   readyWrite,
    output logic                   full,
    output logic                   halfFull,
    output logic                   empty,
    output logic                   refreshRequestClockN,
    output logic                   rasN,
    output logic                   casN,
    output logic                   weN,
    output logic                   oeN,
    output logic [ROW_W-1:0]       dramAddr,
    input  wire logic [DATA_W-1:0] dramDataIn,
    output logic [DATA_W-1:0]      dramDataOut,
    output logic                   dramDataOe
);
    typedef struct packed {
        fdc_state_t              state;
        logic                    isWrite;
        logic                    rdReqPrevN;
        logic                    wrReqPrevN;
        logic                    rdPend;
        logic                    wrPend;
        logic                    rfPend;
        logic [RF_TIMER_W-1:0]   rfTimer;
        logic                    rfClkN;
        logic                    rfClkPrevN;
        logic [PTR_W-1:0]        wrPtr;
        logic [PTR_W-1:0]        rdPtr;
        logic [STAT_W-1:0]       status;
        logic                    rasN;
        logic                    casN;
        logic                    weN;
        logic                    oeN;
        logic                    rowColSel;
        logic [ROW_W-1:0]        addr;
        logic                    rdyRd;
        logic                    rdyWr;
        logic                    full;
        logic                    halfFull;
        logic                    empty;
        logic [DATA_W-1:0]       dqOut;
        logic                    dqOe;
        logic [DATA_W-1:0]       rdData;
        logic                    rdValid;
    } fdc_ctrl_st_t;

    fdc_ctrl_st_t q;
    fdc_ctrl_st_t n;

    fdc_stream_if #(.W(DATA_W)) fillIf ();
    fdc_stream_if #(.W(DATA_W)) drainIf ();

    logic accessEnable;
    logic refreshEnable;
    logic grantWr;
    logic grantRd;
    logic wrCan;
    logic rdCan;
    logic rfSet;
    logic rdSet;
    logic wrSet;
    logic rdClr;
    logic wrClr;
    logic rfClr;
    logic rasActive;
    logic [PTR_W-1:0] accPtr;

    // Selects the row or column half of a pointer for the address pins.
    function automatic logic [ROW_W-1:0] fdc_half(input logic [PTR_W-1:0] ptr,
                                                 input logic             rowSel);
        if (rowSel)
            return ptr[ROW_W-1:0];
        else
            return ptr[PTR_W-1:ROW_W];
    endfunction : fdc_half

    // Incoming write words are buffered before they reach the DRAM data pins.
    assign fillIf.valid   = writeDataValid;
    assign fillIf.data    = writeData;
    assign writeDataReady = fillIf.ready;
    assign drainIf.ready  = grantWr;

    fdc_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) writeBuffer (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .fillPort  (fillIf),
        .drainPort (drainIf)
    );

    // Access and refresh come from disjoint one-hot states, so they never overlap.
    assign accessEnable  = (q.state == ST_ROW) || (q.state == ST_RAS) ||
                           (q.state == ST_COL) || (q.state == ST_CAS) ||
                           (q.state == ST_HOLD);
    assign refreshEnable = (q.state == ST_RFCAS) || (q.state == ST_RFRAS);

    // Request edges, arbitration inputs and the pointer in use.
    assign rfSet  = q.rfClkPrevN & ~q.rfClkN;
    assign rdSet  = q.rdReqPrevN & ~readRequestN;
    assign wrSet  = q.wrReqPrevN & ~writeRequestN;
    assign wrCan  = q.wrPend & drainIf.valid & ~q.full;
    assign rdCan  = q.rdPend & ~q.empty;
    assign accPtr = q.isWrite ? q.wrPtr : q.rdPtr;

    // Grants: refresh first, then a write that can proceed, then a read.
    always_comb
    begin
        grantWr = 1'b0;
        grantRd = 1'b0;
        if ((q.state == ST_IDLE) && !q.rfPend)
        begin
            if (wrCan)
                grantWr = 1'b1;
            else if (rdCan)
                grantRd = 1'b1;
        end
    end

    // RAS follows the excitation equation plus a hold term for the access body.
    assign rasActive = (accessEnable & q.rasN & q.rowColSel & q.casN)
                     | (refreshEnable & ~q.casN & q.rasN)
                     | (accessEnable & ~q.rasN & (q.state != ST_HOLD));

    // Completion strobes for the pending request registers.
    assign rdClr = (q.state == ST_HOLD) && !q.isWrite;
    assign wrClr = (q.state == ST_HOLD) && q.isWrite;
    assign rfClr = (q.state == ST_RFRAS);

    // Next state of the whole controller.
    always_comb
    begin
        n = q;
        n.rdValid = 1'b0;

        // Internal refresh request clock: low for the first part of each period.
        if (q.rfTimer == RF_TIMER_W'(REFRESH_PERIOD_CYC - 1))
            n.rfTimer = '0;
        else
            n.rfTimer = q.rfTimer + 1'b1;
        n.rfClkN     = (n.rfTimer >= RF_TIMER_W'(REFRESH_LOW_CYC));
        n.rfClkPrevN = q.rfClkN;
        n.rdReqPrevN = readRequestN;
        n.wrReqPrevN = writeRequestN;

        // Pending requests; a new request wins over the clear in the same cycle.
        n.rfPend = (q.rfPend & ~rfClr) | rfSet;
        n.rdPend = (q.rdPend & ~rdClr) | rdSet;
        n.wrPend = (q.wrPend & ~wrClr) | wrSet;

        case (q.state)
            ST_IDLE:
            begin
                if (q.rfPend)
                begin
                    n.state = ST_RFCAS;
                    n.casN  = 1'b0;
                end
                else if (grantWr)
                begin
                    n.state     = ST_ROW;
                    n.isWrite   = 1'b1;
                    n.dqOut     = drainIf.data;
                    n.rowColSel = 1'b1;
                    n.addr      = fdc_half(q.wrPtr, 1'b1);
                    n.status    = q.status + 1'b1;
                end
                else if (grantRd)
                begin
                    n.state     = ST_ROW;
                    n.isWrite   = 1'b0;
                    n.rowColSel = 1'b1;
                    n.addr      = fdc_half(q.rdPtr, 1'b1);
                    n.status    = q.status - 1'b1;
                end
            end
            ST_ROW:
            begin
                n.state = ST_RAS;
            end
            ST_RAS:
            begin
                n.state     = ST_COL;
                n.rowColSel = 1'b0;
                n.addr      = fdc_half(accPtr, 1'b0);
                n.weN       = ~q.isWrite;
                n.oeN       = q.isWrite;
                n.dqOe      = q.isWrite;
            end
            ST_COL:
            begin
                n.state = ST_CAS;
                n.casN  = 1'b0;
            end
            ST_CAS:
            begin
                n.state = ST_HOLD;
            end
            ST_HOLD:
            begin
                n.state     = ST_IDLE;
                n.casN      = STROBE_OFF;
                n.weN       = STROBE_OFF;
                n.oeN       = STROBE_OFF;
                n.dqOe      = 1'b0;
                n.rowColSel = 1'b1;
                if (q.isWrite)
                begin
                    n.wrPtr = q.wrPtr + 1'b1;
                end
                else
                begin
                    n.rdPtr   = q.rdPtr + 1'b1;
                    n.rdData  = dramDataIn;
                    n.rdValid = 1'b1;
                end
            end
            ST_RFCAS:
            begin
                n.state = ST_RFRAS;
            end
            ST_RFRAS:
            begin
                n.state = ST_IDLE;
                n.casN  = STROBE_OFF;
            end
            default:
            begin
                n.state = ST_IDLE;
            end
        endcase

        n.rasN = ~rasActive;

        // Ready outputs fall on a pending or running request of their kind or any refresh.
        n.rdyRd = ~(n.rfPend | (n.state == ST_RFCAS) | (n.state == ST_RFRAS)
                    | n.rdPend);
        n.rdyWr = ~(n.rfPend | (n.state == ST_RFCAS) | (n.state == ST_RFRAS)
                    | n.wrPend);

        // Status flags; half-full is a monitor only and feeds no grant.
        n.empty    = (n.status == STATUS_EMPTY);
        n.full     = (n.status == STATUS_FULL);
        n.halfFull = n.status[HALF_BIT];
    end

    // State register; reset leaves the buffer empty with every strobe inactive.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            q            <= '0;
            q.state      <= ST_IDLE;
            q.rdReqPrevN <= 1'b1;
            q.wrReqPrevN <= 1'b1;
            q.rfClkN     <= 1'b1;
            q.rfClkPrevN <= 1'b1;
            q.wrPtr      <= PTR_RESET;
            q.rdPtr      <= PTR_RESET;
            q.status     <= STATUS_EMPTY;
            q.rasN       <= STROBE_OFF;
            q.casN       <= STROBE_OFF;
            q.weN        <= STROBE_OFF;
            q.oeN        <= STROBE_OFF;
            q.rowColSel  <= 1'b1;
            q.rdyRd      <= 1'b1;
            q.rdyWr      <= 1'b1;
            q.empty      <= 1'b1;
        end
        else
        begin
            q <= n;
        end
    end

    // Outputs straight from the state register.
    assign readData             = q.rdData;
    assign readDataValid        = q.rdValid;
    assign readyRead            = q.rdyRd;
    assign readyWrite           = q.rdyWr;
    assign full                 = q.full;
    assign halfFull             = q.halfFull;
    assign empty                = q.empty;
    assign refreshRequestClockN = q.rfClkN;
    assign rasN                 = q.rasN;
    assign casN                 = q.casN;
    assign weN                  = q.weN;
    assign oeN                  = q.oeN;
    assign dramAddr             = q.addr;
    assign dramDataOut          = q.dqOut;
    assign dramDataOe           = q.dqOe;
endmodule : fdc_controller

`default_nettype wire

//--- fdc_controller_props.sv
// Port-level assertion checker for the FIFO DRAM controller.
`default_nettype none

module fdc_controller_props
    import fdc_pkg::*;
#(
    parameter int DATA_W = DATA_W_DEF
) (
    input wire logic              mclk,
    input wire logic              rst_b,
    input wire logic              readyRead,
    input wire logic              readyWrite,
    input wire logic              full,
    input wire logic              empty,
    input wire logic              refreshRequestClockN,
    input wire logic              rasN,
    input wire logic              casN,
    input wire logic              weN,
    input wire logic              oeN,
    input wire logic [ROW_W-1:0]  dramAddr,
    input wire logic [DATA_W-1:0] dramDataIn,
    input wire logic [DATA_W-1:0] readData,
    input wire logic              readDataValid,
    input wire logic              dramDataOe
);
    logic [PTR_W-1:0] wrPtr_q;
    logic [PTR_W-1:0] rdPtr_q;

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);

    // Mirrors both pointers: every finished access advances its own pointer.
    always_ff @(posedge mclk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wrPtr_q <= PTR_RESET;
            rdPtr_q <= PTR_RESET;
        end
        else
        begin
            if ($rose(weN)) wrPtr_q <= wrPtr_q + 16'h0001;
            if ($rose(oeN)) rdPtr_q <= rdPtr_q + 16'h0001;
        end
    end

    sequence s_rfEnd;
        !rasN && !casN ##1 rasN && casN;
    endsequence
    sequence s_casEnd;
        !casN ##2 rasN && casN && weN && oeN;
    endsequence

    property p_refreshReady;
        $fell(refreshRequestClockN) |=> !readyRead && !readyWrite;
    endproperty
    property p_refreshOrder;
        $fell(casN) && rasN |=> s_rfEnd;
    endproperty
    property p_refreshQuiet;
        !casN && rasN |-> weN && oeN && !dramDataOe;
    endproperty
    property p_writeSeq;
        $fell(weN) |-> !rasN && casN && dramDataOe && dramAddr == wrPtr_q[15:8]
            && $past(dramAddr) == wrPtr_q[7:0] ##1 s_casEnd;
    endproperty
    property p_readSeq;
        $fell(oeN) |-> weN && !rasN && casN && dramAddr == rdPtr_q[15:8]
            && $past(dramAddr) == rdPtr_q[7:0] ##1 s_casEnd;
    endproperty
    property p_readData;
        $rose(oeN) |-> readDataValid && readData == $past(dramDataIn);
    endproperty
    property p_readNotEmpty;
        $fell(oeN) |-> !$past(empty, 3);
    endproperty
    property p_writeNotFull;
        $fell(weN) |-> !$past(full, 3);
    endproperty
    property p_idleStrobes;
        readyRead && readyWrite |-> rasN && casN && weN && oeN;
    endproperty

    a_refreshReady: assert property (p_refreshReady)
        else $error("Readies stayed high on refresh request");
    a_refreshOrder: assert property (p_refreshOrder)
        else $error("Refresh strobe order wrong");
    a_refreshQuiet: assert property (p_refreshQuiet)
        else $error("Access strobe active during refresh");
    a_writeSeq: assert property (p_writeSeq)
        else $error("Write strobe or address sequence wrong");
    a_readSeq: assert property (p_readSeq)
        else $error("Read strobe or address sequence wrong");
    a_readData: assert property (p_readData)
        else $error("Read word not delivered at access end");
    a_readNotEmpty: assert property (p_readNotEmpty)
        else $error("Read granted while empty");
    a_writeNotFull: assert property (p_writeNotFull)
        else $error("Write granted while full");
    a_idleStrobes: assert property (p_idleStrobes)
        else $error("Strobe active while idle");
endmodule : fdc_controller_props

bind fdc_controller fdc_controller_props #(.DATA_W(DATA_W)) u_props (.mclk(mclk),
    .rst_b(rst_b), .readyRead(readyRead), .readyWrite(readyWrite), .full(full),
    .empty(empty), .refreshRequestClockN(refreshRequestClockN), .rasN(rasN),
    .casN(casN), .weN(weN), .oeN(oeN), .dramAddr(dramAddr), .dramDataIn(dramDataIn),
    .readData(readData), .readDataValid(readDataValid), .dramDataOe(dramDataOe));

`default_nettype wire

//--- fdc_dram_model.sv
// Behavioural DRAM array answering the controller's strobes.
`default_nettype none

module fdc_dram_model
    import fdc_pkg::*;
#(
    parameter int DATA_W = DATA_W_DEF
) (
    input  wire logic              mclk,
    input  wire logic              rasN,
    input  wire logic              casN,
    input  wire logic              weN,
    input  wire logic              oeN,
    input  wire logic [ROW_W-1:0]  dramAddr,
    input  wire logic [DATA_W-1:0] dramDataOut,
    output logic      [DATA_W-1:0] dramDataIn
);
    timeunit 1ns;
    timeprecision 1ns;

    logic [DATA_W-1:0] mem [0:65535];
    logic [ROW_W-1:0]  rowQ;
    logic [ROW_W-1:0]  colQ;
    logic              rasPrev = 1'b1;
    logic              casPrev = 1'b1;
    logic [DATA_W-1:0] idlePat = '0;

    // Row latches on RAS, column and write data on CAS; CAS first only refreshes.
    always @(posedge mclk)
    begin
        rasPrev <= rasN;
        casPrev <= casN;
        idlePat <= ~idlePat;
        if (!rasN && rasPrev && casN) rowQ <= dramAddr;
        if (!casN && casPrev && !rasN)
        begin
            colQ <= dramAddr;
            if (!weN) mem[{dramAddr, rowQ}] <= dramDataOut;
        end
    end

    // The array drives only while selected; otherwise the pins show a changing pattern.
    assign dramDataIn = (!oeN && !casN && !rasN) ? mem[{colQ, rowQ}] : idlePat;
endmodule : fdc_dram_model

`default_nettype wire

//--- tb_fdc_controller.sv
// Self-checking testbench for the FIFO DRAM controller.
`default_nettype none

module tb_fdc_controller
    import fdc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;

    logic       mclk;
    logic       rst_b;
    logic       readRequestN;
    logic       writeRequestN;
    logic [7:0] writeData;
    logic       writeDataValid;
    logic       writeDataReady;
    logic [7:0] readData;
    logic       readDataValid;
    logic       readyRead;
    logic       readyWrite;
    logic       full;
    logic       halfFull;
    logic       empty;
    logic       refreshRequestClockN;
    logic       rasN;
    logic       casN;
    logic       weN;
    logic       oeN;
    logic [7:0] dramAddr;
    logic [7:0] dramDataIn;
    logic [7:0] dramDataOut;
    logic       dramDataOe;
    logic [7:0] got [$];
    int         n_errors = 0;
    int         total_checks = 0;

    fdc_controller dut (.mclk(mclk), .rst_b(rst_b), .readRequestN(readRequestN),
        .writeRequestN(writeRequestN), .writeData(writeData),
        .writeDataValid(writeDataValid), .writeDataReady(writeDataReady),
        .readData(readData), .readDataValid(readDataValid), .readyRead(readyRead),
        .readyWrite(readyWrite), .full(full), .halfFull(halfFull), .empty(empty),
        .refreshRequestClockN(refreshRequestClockN), .rasN(rasN), .casN(casN),
        .weN(weN), .oeN(oeN), .dramAddr(dramAddr), .dramDataIn(dramDataIn),
        .dramDataOut(dramDataOut), .dramDataOe(dramDataOe));

    fdc_dram_model u_dram (.mclk(mclk), .rasN(rasN), .casN(casN), .weN(weN),
        .oeN(oeN), .dramAddr(dramAddr), .dramDataOut(dramDataOut),
        .dramDataIn(dramDataIn));

    // Free-running 10 MHz clock.
    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    // Collects every word the controller hands back.
    always @(negedge mclk) if (readDataValid === 1'b1) got.push_back(readData);

    task automatic check_bit(input logic g, input logic e);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("ERROR %0t flag got %b expected %b", $time, g, e);
        end
    endtask : check_bit

    task automatic check_byte(input logic [7:0] g, input logic [7:0] e);
        total_checks++;
        if (g !== e)
        begin
            n_errors++;
            $display("ERROR %0t word got %h expected %h", $time, g, e);
        end
    endtask : check_byte

    task automatic finish_test();
        if (n_errors == 0 && total_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    // Offers one word to the write FIFO; valid stays up for the caller to drop.
    task automatic push_word(input logic [7:0] d);
        writeData      <= d;
        writeDataValid <= 1'b1;
        do @(posedge mclk); while (writeDataReady !== 1'b1);
    endtask : push_word

    // Pulses the chosen request lines low for one cycle.
    task automatic request(input logic wr, input logic rd);
        if (wr) writeRequestN <= 1'b0;
        if (rd) readRequestN <= 1'b0;
        @(posedge mclk);
        writeRequestN <= 1'b1;
        readRequestN  <= 1'b1;
    endtask : request

    // Waits, bounded, until the chosen ready output is back high.
    task automatic wait_done(input logic wr);
        int n;
        n = 0;
        @(posedge mclk);
        while ((wr ? readyWrite : readyRead) !== 1'b1 && n < 100)
        begin
            @(posedge mclk);
            n++;
        end
        check_bit(wr ? readyWrite : readyRead, 1'b1);
    endtask : wait_done

    // Cuts a hang short.
    initial
    begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        $display("ERROR %0t run did not complete", $time);
        finish_test();
    end

    // Main sequence.
    initial
    begin
        rst_b = 1'b0;
        readRequestN = 1'b1;
        writeRequestN = 1'b1;
        writeData = 8'h00;
        writeDataValid = 1'b0;
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        @(negedge mclk);
        check_byte({empty, full, halfFull, readyRead, readyWrite, rasN, casN,
            writeDataReady}, 8'h9F);
        check_byte({weN, oeN, dramDataOe, readDataValid, 4'h0}, 8'hC0);
        @(posedge mclk);
        request(1'b0, 1'b1);
        repeat (20) @(posedge mclk);
        check_bit(readyRead, 1'b0);
        for (int i = 0; i < 16; i++) push_word(8'hA0 + 8'(i));
        writeDataValid <= 1'b0;
        @(negedge mclk);
        check_bit(writeDataReady, 1'b0);
        @(posedge mclk);
        for (int i = 0; i < 16; i++)
        begin
            request(1'b1, 1'b0);
            wait_done(1'b1);
        end
        wait_done(1'b0);
        check_bit(writeDataReady, 1'b1);
        check_bit(halfFull, 1'b0);
        for (int i = 0; i < 15; i++)
        begin
            request(1'b0, 1'b1);
            wait_done(1'b0);
        end
        check_bit(empty, 1'b1);
        check_byte(8'(got.size()), 8'h10);
        for (int i = 0; i < 16; i++) check_byte(got[i], 8'hA0 + 8'(i));
        push_word(8'h5A);
        push_word(8'hC3);
        writeDataValid <= 1'b0;
        request(1'b1, 1'b0);
        wait_done(1'b1);
        request(1'b1, 1'b1);
        for (int n = 0; n < 60 && weN !== 1'b0 && oeN !== 1'b0; n++) @(negedge mclk);
        check_bit(weN, 1'b0);
        wait_done(1'b1);
        wait_done(1'b0);
        request(1'b0, 1'b1);
        wait_done(1'b0);
        check_byte(got[16], 8'h5A);
        check_byte(got[17], 8'hC3);
        check_bit(empty, 1'b1);
        // An idle refresh: readies drop, CAS leads RAS, then everything releases together.
        do @(negedge mclk); while (refreshRequestClockN !== 1'b1);
        do @(negedge mclk); while (refreshRequestClockN !== 1'b0);
        @(negedge mclk);
        check_byte({readyRead, readyWrite, casN, rasN, 4'h0}, 8'h30);
        @(negedge mclk);
        check_byte({readyRead, readyWrite, casN, rasN, 4'h0}, 8'h10);
        @(negedge mclk);
        check_byte({readyRead, readyWrite, casN, rasN, 4'h0}, 8'h00);
        @(negedge mclk);
        check_byte({readyRead, readyWrite, casN, rasN, weN, oeN, 2'h0}, 8'hFC);
        finish_test();
    end
endmodule : tb_fdc_controller

`default_nettype wire
